// ---- crg_pkg.sv ----
// constants and types for the cpu register file and change guard
`default_nettype none
package crg_pkg;
  // general purpose register file
  localparam int          GPR_COUNT   = 32;
  localparam int          GPR_W       = 8;
  localparam int          GPR_AW      = 5;
  localparam logic [7:0]  GPR_RESET   = 8'h00;
  // pointer pairs, low byte address of each
  localparam logic [4:0]  PTR_X_LO    = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO    = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO    = 5'h1E;
  localparam logic [4:0]  PTR_HI_BIT  = 5'h01;
  // pointer select codes
  localparam logic [1:0]  PSEL_X      = 2'h0;
  localparam logic [1:0]  PSEL_Y      = 2'h1;
  localparam logic [1:0]  PSEL_Z      = 2'h2;
  // pointer addressing modes
  localparam logic [1:0]  PMODE_DISP  = 2'h0;
  localparam logic [1:0]  PMODE_INC   = 2'h1;
  localparam logic [1:0]  PMODE_DEC   = 2'h2;
  // pointer access kinds
  localparam logic [1:0]  PKIND_DATA  = 2'h0;
  localparam logic [1:0]  PKIND_PROG  = 2'h1;
  localparam logic [1:0]  PKIND_CALL  = 2'h2;
  localparam logic [1:0]  PKIND_JUMP  = 2'h3;
  // i/o offsets
  localparam logic [5:0]  IO_CCK      = 6'h04;
  localparam logic [5:0]  IO_TEMP     = 6'h0C;
  localparam logic [5:0]  IO_STK_LO   = 6'h0D;
  localparam logic [5:0]  IO_STK_HI   = 6'h0E;
  localparam logic [5:0]  IO_FLAGS    = 6'h0F;
  // reset values
  localparam logic [7:0]  TEMP_RESET  = 8'h00;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [7:0]  RDATA_IDLE  = 8'h00;
  // change guard keys and window length
  localparam logic [7:0]  KEY_IO      = 8'hD8;
  localparam logic [7:0]  KEY_SPM     = 8'h9D;
  localparam logic [2:0]  GUARD_INSTR = 3'h4;
  localparam logic [2:0]  CNT_ONE     = 3'h1;
  localparam logic [2:0]  CNT_ZERO    = 3'h0;
  localparam logic [5:0]  CCK_ZERO    = 6'h00;

  typedef enum logic [2:0] {
    GUARD_IDLE = 3'b001,
    GUARD_IO   = 3'b010,
    GUARD_SPM  = 3'b100
  } crg_guard_e;
endpackage
`default_nettype wire

// ---- crg_cpu_regfile.sv ----
// cpu register file, pointer unit, 16-bit temp byte access and change guard
`default_nettype none
module crg_cpu_regfile #(
  parameter logic [15:0] SP_RESET = 16'h3FFF
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [4:0]  rd_a_addr_i,
  input  wire logic [4:0]  rd_b_addr_i,
  input  wire logic        wr_en_i,
  input  wire logic        wr_wide_i,
  input  wire logic [4:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [7:0]  rd_a_data_o,
  output logic      [7:0]  rd_b_data_o,
  output logic      [15:0] rd_word_o,
  input  wire logic        ptr_req_i,
  input  wire logic [1:0]  ptr_kind_i,
  input  wire logic [1:0]  ptr_sel_i,
  input  wire logic [1:0]  ptr_mode_i,
  input  wire logic [5:0]  ptr_disp_i,
  output logic      [15:0] ptr_addr_o,
  output logic      [1:0]  ptr_kind_o,
  output logic             ptr_valid_o,
  input  wire logic [5:0]  io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  input  wire logic        mem_wr_i,
  input  wire logic        nvm_access_i,
  input  wire logic        sleep_i,
  input  wire logic        instr_done_i,
  output logic             io_unlock_o,
  output logic             spm_unlock_o,
  output logic             irq_hold_o,
  output logic      [15:0] stack_pointer_o,
  output logic      [7:0]  status_flags_o
);

  // register file and pointer state
  logic [7:0]  gpr_r       [crg_pkg::GPR_COUNT];
  logic [7:0]  gpr_nxt     [crg_pkg::GPR_COUNT];
  logic [7:0]  rd_a_r;
  logic [7:0]  rd_a_nxt;
  logic [7:0]  rd_b_r;
  logic [7:0]  rd_b_nxt;
  logic [15:0] rd_word_r;
  logic [15:0] rd_word_nxt;
  logic [15:0] ptr_addr_r;
  logic [15:0] ptr_addr_nxt;
  logic [1:0]  ptr_kind_r;
  logic [1:0]  ptr_kind_nxt;
  logic        ptr_valid_r;
  logic        ptr_valid_nxt;
  logic [4:0]  ptr_lo;
  logic [4:0]  ptr_hi;
  logic [4:0]  word_lo;
  logic [4:0]  wr_lo;
  logic [1:0]  eff_sel;
  logic [1:0]  eff_mode;
  logic [15:0] eff_disp;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_upd;

  // guard and i/o state
  crg_pkg::crg_guard_e guard_r;
  crg_pkg::crg_guard_e guard_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic [7:0]  temp_r;
  logic [7:0]  temp_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  io_rdata_r;
  logic [7:0]  io_rdata_nxt;
  logic        io_unlock_r;
  logic        spm_unlock_r;
  logic        irq_hold_r;
  logic        key_wr;

  // program load and indirect flow force third pointer
  always_comb begin
    if (ptr_kind_i == crg_pkg::PKIND_DATA) begin
      eff_sel = ptr_sel_i;
    end else begin
      eff_sel = crg_pkg::PSEL_Z;
    end
  end

  always_comb begin
    case (eff_sel)
      crg_pkg::PSEL_X: ptr_lo = crg_pkg::PTR_X_LO;
      crg_pkg::PSEL_Y: ptr_lo = crg_pkg::PTR_Y_LO;
      default:         ptr_lo = crg_pkg::PTR_Z_LO;
    endcase
  end

  assign ptr_hi  = ptr_lo | crg_pkg::PTR_HI_BIT;
  assign ptr_cur = {gpr_r[ptr_hi], gpr_r[ptr_lo]};
  assign word_lo = {rd_a_addr_i[4:1], 1'b0};
  assign wr_lo   = {wr_addr_i[4:1], 1'b0};

  // calls and jumps take the pointer as is; displacement only for data
  always_comb begin
    if (ptr_kind_i == crg_pkg::PKIND_CALL || ptr_kind_i == crg_pkg::PKIND_JUMP) begin
      eff_mode = crg_pkg::PMODE_DISP;
    end else begin
      eff_mode = ptr_mode_i;
    end
    if (ptr_kind_i == crg_pkg::PKIND_DATA) begin
      eff_disp = {10'h000, ptr_disp_i};
    end else begin
      eff_disp = 16'h0000;
    end
  end

  always_comb begin
    case (eff_mode)
      crg_pkg::PMODE_INC: begin
        ptr_addr_nxt = ptr_cur;
        ptr_upd      = ptr_cur + 16'h0001;
      end
      crg_pkg::PMODE_DEC: begin
        ptr_addr_nxt = ptr_cur - 16'h0001;
        ptr_upd      = ptr_cur - 16'h0001;
      end
      default: begin
        ptr_addr_nxt = ptr_cur + eff_disp;
        ptr_upd      = ptr_cur;
      end
    endcase
  end

  // register file next state
  always_comb begin
    for (int i = 0; i < crg_pkg::GPR_COUNT; i++) begin
      gpr_nxt[i] = gpr_r[i];
    end
    if (ptr_req_i && eff_mode != crg_pkg::PMODE_DISP) begin
      gpr_nxt[ptr_lo] = ptr_upd[7:0];
      gpr_nxt[ptr_hi] = ptr_upd[15:8];
    end
    // result port wins over a pointer step on the same register
    if (wr_en_i) begin
      if (wr_wide_i) begin
        gpr_nxt[wr_lo]              = wr_data_i[7:0];
        gpr_nxt[wr_lo | 5'h01]      = wr_data_i[15:8];
      end else begin
        gpr_nxt[wr_addr_i]          = wr_data_i[7:0];
      end
    end
    // two byte operands and one word operand
    rd_a_nxt      = gpr_r[rd_a_addr_i];
    rd_b_nxt      = gpr_r[rd_b_addr_i];
    rd_word_nxt   = {gpr_r[word_lo | 5'h01], gpr_r[word_lo]};
    ptr_kind_nxt  = ptr_kind_i;
    ptr_valid_nxt = ptr_req_i;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < crg_pkg::GPR_COUNT; i++) begin
        gpr_r[i] <= crg_pkg::GPR_RESET;
      end
      rd_a_r      <= crg_pkg::GPR_RESET;
      rd_b_r      <= crg_pkg::GPR_RESET;
      rd_word_r   <= 16'h0000;
      ptr_addr_r  <= 16'h0000;
      ptr_kind_r  <= crg_pkg::PKIND_DATA;
      ptr_valid_r <= 1'b0;
    end else begin
      for (int i = 0; i < crg_pkg::GPR_COUNT; i++) begin
        gpr_r[i] <= gpr_nxt[i];
      end
      rd_a_r      <= rd_a_nxt;
      rd_b_r      <= rd_b_nxt;
      rd_word_r   <= rd_word_nxt;
      ptr_addr_r  <= ptr_addr_nxt;
      ptr_kind_r  <= ptr_kind_nxt;
      ptr_valid_r <= ptr_valid_nxt;
    end
  end

  assign key_wr = io_wr_i && (io_addr_i == crg_pkg::IO_CCK);

  // guard window next state
  always_comb begin
    guard_nxt = guard_r;
    cnt_nxt   = cnt_r;
    case (guard_r)
      crg_pkg::GUARD_IDLE: begin
        cnt_nxt = crg_pkg::CNT_ZERO;
      end
      crg_pkg::GUARD_IO: begin
        if (instr_done_i) begin
          cnt_nxt = cnt_r - crg_pkg::CNT_ONE;
        end
        // an i/o or memory write, nvm access or sleep ends the window
        if ((instr_done_i && cnt_r == crg_pkg::CNT_ONE) || io_wr_i || mem_wr_i || nvm_access_i || sleep_i) begin
          guard_nxt = crg_pkg::GUARD_IDLE;
        end
      end
      crg_pkg::GUARD_SPM: begin
        if (instr_done_i) begin
          cnt_nxt = cnt_r - crg_pkg::CNT_ONE;
        end
        // four instructions, nvm access or sleep end it
        if ((instr_done_i && cnt_r == crg_pkg::CNT_ONE) || nvm_access_i || sleep_i) begin
          guard_nxt = crg_pkg::GUARD_IDLE;
        end
      end
      default: begin
        guard_nxt = crg_pkg::GUARD_IDLE;
        cnt_nxt   = crg_pkg::CNT_ZERO;
      end
    endcase
    // only the two keys open a window
    if (key_wr && io_wdata_i == crg_pkg::KEY_IO) begin
      guard_nxt = crg_pkg::GUARD_IO;
      cnt_nxt   = crg_pkg::GUARD_INSTR;
    end else if (key_wr && io_wdata_i == crg_pkg::KEY_SPM) begin
      guard_nxt = crg_pkg::GUARD_SPM;
      cnt_nxt   = crg_pkg::GUARD_INSTR;
    end
  end

  // i/o register next state
  always_comb begin
    temp_nxt     = temp_r;
    sp_nxt       = sp_r;
    flags_nxt    = flags_r;
    io_rdata_nxt = crg_pkg::RDATA_IDLE;
    // only guard, temp, stack and flags answer; the register file never does
    if (io_rd_i) begin
      case (io_addr_i)
        // window flags in bits 0 and 1, others zero
        crg_pkg::IO_CCK:    io_rdata_nxt = {crg_pkg::CCK_ZERO, spm_unlock_r, io_unlock_r};
        crg_pkg::IO_TEMP:   io_rdata_nxt = temp_r;
        // low read latches the high byte
        crg_pkg::IO_STK_LO: begin
          io_rdata_nxt = sp_r[7:0];
          temp_nxt     = sp_r[15:8];
        end
        // high read returns temp, never the live byte
        crg_pkg::IO_STK_HI: io_rdata_nxt = temp_r;
        crg_pkg::IO_FLAGS:  io_rdata_nxt = flags_r;
        default:            io_rdata_nxt = crg_pkg::RDATA_IDLE;
      endcase
    end
    if (io_wr_i) begin
      case (io_addr_i)
        crg_pkg::IO_TEMP:   temp_nxt = io_wdata_i;
        crg_pkg::IO_STK_LO: temp_nxt = io_wdata_i;
        // high write commits both bytes at once
        crg_pkg::IO_STK_HI: sp_nxt = {io_wdata_i, temp_r};
        crg_pkg::IO_FLAGS:  flags_nxt = io_wdata_i;
        default:            temp_nxt = temp_nxt;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      guard_r      <= crg_pkg::GUARD_IDLE;
      cnt_r        <= crg_pkg::CNT_ZERO;
      temp_r       <= crg_pkg::TEMP_RESET;
      sp_r         <= SP_RESET;
      flags_r      <= crg_pkg::FLAGS_RESET;
      io_rdata_r   <= crg_pkg::RDATA_IDLE;
      io_unlock_r  <= 1'b0;
      spm_unlock_r <= 1'b0;
      irq_hold_r   <= 1'b0;
    end else begin
      guard_r      <= guard_nxt;
      cnt_r        <= cnt_nxt;
      temp_r       <= temp_nxt;
      sp_r         <= sp_nxt;
      flags_r      <= flags_nxt;
      io_rdata_r   <= io_rdata_nxt;
      // protected targets accept changes only while unlocked
      io_unlock_r  <= (guard_nxt == crg_pkg::GUARD_IO);
      // self-programming unlock is a separate mode
      spm_unlock_r <= (guard_nxt == crg_pkg::GUARD_SPM);
      irq_hold_r   <= (guard_nxt != crg_pkg::GUARD_IDLE);
    end
  end

  // read data lags the request by one cycle; no write bypass
  assign rd_a_data_o     = rd_a_r;
  assign rd_b_data_o     = rd_b_r;
  assign rd_word_o       = rd_word_r;
  assign ptr_addr_o      = ptr_addr_r;
  assign ptr_kind_o      = ptr_kind_r;
  assign ptr_valid_o     = ptr_valid_r;
  assign io_rdata_o      = io_rdata_r;
  assign io_unlock_o     = io_unlock_r;
  assign spm_unlock_o    = spm_unlock_r;
  assign irq_hold_o      = irq_hold_r;
  assign stack_pointer_o = sp_r;
  assign status_flags_o  = flags_r;

endmodule
`default_nettype wire

// ---- crg_cpu_regfile_checker.sv ----
// concurrent checks on the register file and change guard ports
`default_nettype none
module crg_cpu_regfile_checker (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        wr_en_i,
  input wire logic        wr_wide_i,
  input wire logic [4:0]  wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [4:0]  rd_a_addr_i,
  input wire logic [15:0] rd_word_o,
  input wire logic        ptr_req_i,
  input wire logic [1:0]  ptr_kind_i,
  input wire logic [1:0]  ptr_kind_o,
  input wire logic        ptr_valid_o,
  input wire logic [5:0]  io_addr_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic [7:0]  io_rdata_o,
  input wire logic        mem_wr_i,
  input wire logic        nvm_access_i,
  input wire logic        sleep_i,
  input wire logic        instr_done_i,
  input wire logic        io_unlock_o,
  input wire logic        spm_unlock_o,
  input wire logic        irq_hold_o,
  input wire logic [15:0] stack_pointer_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic       key_wr;
  logic       good_key;
  logic [2:0] instr_seen_r;
  assign key_wr   = io_wr_i && io_addr_i == crg_pkg::IO_CCK;
  assign good_key = key_wr && (io_wdata_i == crg_pkg::KEY_IO || io_wdata_i == crg_pkg::KEY_SPM);
  a_io_key_open: assert property (
    key_wr && io_wdata_i == crg_pkg::KEY_IO |=> io_unlock_o && irq_hold_o && !spm_unlock_o)
    else $error("io key did not open window");
  a_spm_key_open: assert property (
    key_wr && io_wdata_i == crg_pkg::KEY_SPM |=> spm_unlock_o && irq_hold_o && !io_unlock_o)
    else $error("spm key did not open window");
  a_bad_key_shut: assert property (
    key_wr && !good_key && !spm_unlock_o |=> !io_unlock_o && !spm_unlock_o)
    else $error("wrong key opened a window");
  a_io_close_evt: assert property (
    io_unlock_o && (io_wr_i || mem_wr_i || nvm_access_i || sleep_i) && !good_key |=> !io_unlock_o)
    else $error("io window stayed open");
  a_spm_close_evt: assert property (
    spm_unlock_o && (nvm_access_i || sleep_i) && !good_key |=> !spm_unlock_o)
    else $error("spm window stayed open");
  a_hold_any_window: assert property (
    irq_hold_o == (io_unlock_o || spm_unlock_o))
    else $error("interrupt hold disagrees with windows");
  // instructions seen since the last good key, counted only while a window is open
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      instr_seen_r <= 3'h0;
    end else if (good_key) begin
      instr_seen_r <= 3'h0;
    end else if (irq_hold_o && instr_done_i) begin
      instr_seen_r <= instr_seen_r + 3'h1;
    end
  end
  a_window_four_instr: assert property (
    irq_hold_o && instr_done_i && !good_key && instr_seen_r == 3'h3 |=> !irq_hold_o)
    else $error("window outlived four instructions");
  a_guard_readback: assert property (
    io_rd_i && io_addr_i == crg_pkg::IO_CCK |=> io_rdata_o == {6'h00, $past(spm_unlock_o), $past(io_unlock_o)})
    else $error("guard readback wrong");
  a_word_write_read: assert property (
    wr_en_i && wr_wide_i && !ptr_req_i ##1 rd_a_addr_i[4:1] == $past(wr_addr_i[4:1]) && !wr_en_i && !ptr_req_i
    |=> rd_word_o == $past(wr_data_i, 2))
    else $error("word write not read back");
  a_sp_pair_write: assert property (
    io_wr_i && io_addr_i == crg_pkg::IO_STK_LO ##1 !io_wr_i ##1 io_wr_i && io_addr_i == crg_pkg::IO_STK_HI
    |=> stack_pointer_o == {$past(io_wdata_i), $past(io_wdata_i, 3)})
    else $error("stack pointer pair write wrong");
  a_ptr_answer_next: assert property (
    ptr_req_i |=> ptr_valid_o && ptr_kind_o == $past(ptr_kind_i))
    else $error("pointer answer missing");
endmodule
bind crg_cpu_regfile crg_cpu_regfile_checker u_crg_cpu_regfile_checker (.*);
`default_nettype wire

// ---- crg_pipe_model.sv ----
// pipeline model: i/o byte accesses and instruction events
`default_nettype none
module crg_pipe_model (
  input  wire logic       clock_i,
  output var  logic [5:0] io_addr_o,
  output var  logic       io_wr_o,
  output var  logic       io_rd_o,
  output var  logic [7:0] io_wdata_o,
  output var  logic [3:0] event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_addr_o  = 6'h00;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
    event_o    = 4'h0;
  end
  // one byte per access, caller orders low then high
  task automatic io_put(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock_i);
    io_addr_o  = a;
    io_wdata_o = d;
    io_wr_o    = 1'b1;
    @(negedge clock_i);
    io_wr_o    = 1'b0;
    // released data must not look valid
    io_wdata_o = ~d;
    io_addr_o  = ~a;
  endtask
  task automatic io_get(input logic [5:0] a);
    @(negedge clock_i);
    io_addr_o = a;
    io_rd_o   = 1'b1;
    @(negedge clock_i);
    io_rd_o   = 1'b0;
    io_addr_o = ~a;
  endtask
  // ev bits: sleep, nvm access, memory write, instruction done
  task automatic step(input logic [3:0] ev);
    @(negedge clock_i);
    event_o = ev;
    @(negedge clock_i);
    event_o = 4'h0;
  endtask
endmodule
`default_nettype wire

// ---- cpu_regfile_and_change_guard_tb_top.sv ----
// self-checking bench for the register file and change guard
`default_nettype none
module cpu_regfile_and_change_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, nrst_i, wr_en, wr_wide, ptr_req, io_wr, io_rd, ptr_valid, io_unlock, spm_unlock, irq_hold, rd_p;
  logic [4:0]  rd_a_addr, rd_b_addr, wr_addr;
  logic [15:0] wr_data, rd_word, ptr_addr, sp, v;
  logic [1:0]  ptr_kind, ptr_sel, ptr_mode, kind_o;
  logic [5:0]  ptr_disp, io_addr;
  logic [7:0]  io_wdata, io_rdata, flags, b, rd_a_data, rd_b_data;
  logic [3:0]  ev;
  logic [16:0] exp_q[$];
  logic [16:0] exp_w;
  int          n_fail = 0, check_count = 0;
  integer      seed;
  wire logic [2:0] gst = {irq_hold, spm_unlock, io_unlock};
  logic [7:0]  key[6] = '{8'hD8, 8'h9D, 8'h9D, 8'hD8, 8'h9D, 8'hD8};
  logic [3:0]  cev[6] = '{4'h2, 4'h2, 4'h4, 4'h8, 4'h8, 4'h0};
  logic [2:0]  cex[6] = '{3'b000, 3'b110, 3'b000, 3'b000, 3'b000, 3'b000};
  crg_cpu_regfile u_crg_cpu_regfile (.clock_i(clock_i), .nrst_i(nrst_i), .rd_a_addr_i(rd_a_addr),
    .rd_b_addr_i(rd_b_addr), .wr_en_i(wr_en), .wr_wide_i(wr_wide), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_a_data_o(rd_a_data), .rd_b_data_o(rd_b_data), .rd_word_o(rd_word), .ptr_req_i(ptr_req),
    .ptr_kind_i(ptr_kind),
    .ptr_sel_i(ptr_sel), .ptr_mode_i(ptr_mode), .ptr_disp_i(ptr_disp), .ptr_addr_o(ptr_addr),
    .ptr_kind_o(kind_o), .ptr_valid_o(ptr_valid), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .mem_wr_i(ev[1]), .nvm_access_i(ev[2]), .sleep_i(ev[3]),
    .instr_done_i(ev[0]), .io_unlock_o(io_unlock), .spm_unlock_o(spm_unlock), .irq_hold_o(irq_hold),
    .stack_pointer_o(sp), .status_flags_o(flags));
  crg_pipe_model u_crg_pipe_model (.clock_i(clock_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_wdata_o(io_wdata), .event_o(ev));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clock_i);
    {wr_en, wr_wide, wr_addr, wr_data} = {1'b1, w, a, d};
    @(negedge clock_i);
    wr_en = 1'b0;
  endtask
  task automatic ptr(input logic [1:0] k, input logic [1:0] s, input logic [1:0] m, input logic [15:0] e);
    exp_q.push_back({1'b1, e});
    @(negedge clock_i);
    {ptr_req, ptr_kind, ptr_sel, ptr_mode} = {1'b1, k, s, m};
    @(negedge clock_i);
    ptr_req = 1'b0;
  endtask
  task automatic rd_get(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back({9'h000, e});
    u_crg_pipe_model.io_get(a);
  endtask
  // results are taken from the queue in issue order
  always @(posedge clock_i) rd_p <= io_rd;
  always @(negedge clock_i) begin
    if (rd_p === 1'b1) begin
      exp_w = exp_q.pop_front();
      // top bit marks a pointer note; a read note must have it clear
      check("io_rdata_o", {7'h00, exp_w[16], exp_w[7:0]}, {8'h00, io_rdata});
    end
    if (ptr_valid === 1'b1) begin
      exp_w = exp_q.pop_front();
      check("ptr_addr_o", exp_w[15:0], ptr_addr);
      check("ptr note kind", 16'h0001, {15'h0000, exp_w[16]});
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h92c6;
    {nrst_i, wr_en, wr_wide, wr_addr, wr_data, rd_a_addr, rd_b_addr} = '0;
    {ptr_req, ptr_kind, ptr_sel, ptr_mode, ptr_disp} = '0;
    repeat (12) @(negedge clock_i);
    nrst_i = 1'b1;
    check("stack_pointer_o", 16'h3FFF, sp);
    check("status_flags_o", 16'h0000, {8'h00, flags});
    v = 16'($random(seed));
    u_crg_pipe_model.io_put(crg_pkg::IO_STK_LO, v[7:0]);
    u_crg_pipe_model.io_put(crg_pkg::IO_STK_HI, v[15:8]);
    check("stack_pointer_o", v, sp);
    rd_get(crg_pkg::IO_STK_LO, v[7:0]);
    rd_get(crg_pkg::IO_TEMP, v[15:8]);
    u_crg_pipe_model.io_put(crg_pkg::IO_TEMP, ~v[15:8]);
    rd_get(crg_pkg::IO_STK_HI, ~v[15:8]);
    b = 8'($random(seed));
    u_crg_pipe_model.io_put(crg_pkg::IO_FLAGS, b);
    check("status_flags_o", {8'h00, b}, {8'h00, flags});
    rd_get(crg_pkg::IO_FLAGS, b);
    u_crg_pipe_model.io_put(6'h3F, 8'hFF);
    rd_get(6'h3F, 8'h00);
    check("stack_pointer_o", v, sp);
    for (int i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      wr(1'b1, crg_pkg::PTR_X_LO + 5'(2 * i), v);
      rd_a_addr = crg_pkg::PTR_X_LO + 5'(2 * i);
      rd_b_addr = crg_pkg::PTR_X_LO + 5'(2 * i + 1);
      @(negedge clock_i);
      check("rd_word_o", v, rd_word);
      check("rd_a_data_o", {8'h00, v[7:0]}, {8'h00, rd_a_data});
      check("rd_b_data_o", {8'h00, v[15:8]}, {8'h00, rd_b_data});
      ptr(crg_pkg::PKIND_DATA, 2'(i), crg_pkg::PMODE_INC, v);
      ptr(crg_pkg::PKIND_DATA, 2'(i), crg_pkg::PMODE_DEC, v);
      ptr_disp = 6'($random(seed));
      ptr(crg_pkg::PKIND_DATA, 2'(i), crg_pkg::PMODE_DISP, v + 16'(ptr_disp));
    end
    b = 8'($random(seed));
    wr(1'b0, 5'h1F, {8'hFF, b});
    rd_a_addr = 5'h1F;
    @(negedge clock_i);
    check("rd_a_data_o", {8'h00, b}, {8'h00, rd_a_data});
    for (int k = 1; k < 4; k++) ptr(2'(k), crg_pkg::PSEL_X, crg_pkg::PMODE_DISP, {b, v[7:0]});
    for (int j = 0; j < 3; j++) begin
      u_crg_pipe_model.io_put(crg_pkg::IO_CCK, key[j] ^ 8'(j / 2));
      check("guard state", {13'h0, cex[j + 3] | (j == 0 ? 3'b101 : j == 1 ? 3'b110 : 3'b000)}, {13'h0, gst});
      rd_get(crg_pkg::IO_CCK, j == 0 ? 8'h01 : j == 1 ? 8'h02 : 8'h00);
      repeat (3) u_crg_pipe_model.step(4'h1);
      check("guard open", {13'h0, j == 0 ? 3'b101 : j == 1 ? 3'b110 : 3'b000}, {13'h0, gst});
      u_crg_pipe_model.step(4'h1);
      check("guard closed", 16'h0000, {13'h0, gst});
    end
    for (int j = 0; j < 6; j++) begin
      u_crg_pipe_model.io_put(crg_pkg::IO_CCK, key[j]);
      if (cev[j] == 4'h0) u_crg_pipe_model.io_put(crg_pkg::IO_CCK, 8'h5A);
      else u_crg_pipe_model.step(cev[j]);
      check("guard after close", {13'h0, cex[j]}, {13'h0, gst});
    end
    repeat (3) @(negedge clock_i);
    check("pending results", 16'h0000, 16'(exp_q.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
